/* File: src/aufs_pkg.sv */
package aufs_pkg;
    // ----------------------------------------
    // Sizes
    // ----------------------------------------
    localparam int AUFS_INPUTS = 8;
    localparam int AUFS_UNITS = 10;
    localparam int AUFS_UNIT_W = 4;
    localparam int AUFS_DW = 16;
    // ----------------------------------------
    // Unit refresh word layout
    // ----------------------------------------
    localparam logic [3:0] AUFS_OFS_FAULT_STATUS = 4'h9;
    localparam int AUFS_OPEN_LSB = 0;
    localparam int AUFS_ALARM_LSB = 8;
    localparam logic [15:0] AUFS_LIMIT_MIN = 16'h0000;
    localparam logic [15:0] AUFS_LIMIT_MAX = 16'h4000;
    // ----------------------------------------
    // Host APB map
    // ----------------------------------------
    localparam logic [7:0] AUFS_A_CTRL = 8'h00;
    localparam logic [7:0] AUFS_A_CLAIM = 8'h04;
    localparam logic [7:0] AUFS_A_FAULT = 8'h08;
    localparam logic [7:0] AUFS_A_WORD = 8'h0c;
    localparam logic [7:0] AUFS_A_IRQ_STAT = 8'h10;
    localparam logic [7:0] AUFS_A_IRQ_MASK = 8'h14;
    localparam int AUFS_CTRL_SCAN_EN = 0;
    localparam int AUFS_CTRL_RESTART_LSB = 16;
    localparam int AUFS_FAULT_DUP_LSB = 16;
    localparam int AUFS_FAULT_HALT = 30;
    localparam int AUFS_FAULT_SUMMARY = 31;
    localparam int AUFS_IRQ_FAULT = 0;
    localparam int AUFS_IRQ_DUP = 1;
    localparam int AUFS_IRQ_OPEN = 2;
    localparam int AUFS_IRQ_ALARM = 3;
    localparam int AUFS_IRQ_W = 4;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int AUFS_CLK_NS = 5;
    localparam int AUFS_SCAN_NS = 10000;
    localparam int AUFS_SCAN_CYC = AUFS_SCAN_NS / AUFS_CLK_NS;
    localparam int AUFS_ACK_NS = 100;
    localparam int AUFS_ACK_CYC = AUFS_ACK_NS / AUFS_CLK_NS;
endpackage

/* File: src/aufs_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface aufs_link_if;
    import aufs_pkg::*;
    logic refresh_req;
    logic [3:0] word_sel;
    logic unit_restart_bit;
    logic [AUFS_UNIT_W-1:0] unit_no;
    logic refresh_ack;
    logic [AUFS_DW-1:0] refresh_words;

    modport host_controller (output refresh_req, output word_sel, output unit_restart_bit,
                             input unit_no, input refresh_ack, input refresh_words);
    modport unit (input refresh_req, input word_sel, input unit_restart_bit,
                  output unit_no, output refresh_ack, output refresh_words);
endinterface
`default_nettype wire

/* File: src/aufs_chan.sv */
`timescale 1ns/1ps
`default_nettype none
module aufs_chan import aufs_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic sample,
    input wire logic reinit,
    // Input configuration and level
    input wire logic live_zero,
    input wire logic below_thr,
    input wire logic inhibit,
    input wire logic [AUFS_DW-1:0] value,
    input wire logic [AUFS_DW-1:0] lim_lo,
    input wire logic [AUFS_DW-1:0] lim_hi,
    // Flags
    output logic open_flag,
    output logic alarm_flag
);
    typedef struct packed {
        logic out_prev;
        logic open;
        logic alarm;
    } aufs_chan_s;

    aufs_chan_s s_q, s_d;
    logic lim_ok;
    logic outside;

    always_comb begin
        lim_ok = (lim_lo >= AUFS_LIMIT_MIN) && (lim_hi <= AUFS_LIMIT_MAX) && (lim_lo <= lim_hi); // RL18
        outside = lim_ok && !inhibit && ((value < lim_lo) || (value > lim_hi)); // RL4
        s_d = s_q;
        if (reinit) begin
            s_d = '0;
        end else if (sample) begin
            s_d.open = live_zero && below_thr && !inhibit; // RL1 RL16 RL19
            // Must be out on two successive refreshes, i.e. a whole scan
            s_d.alarm = outside && s_q.out_prev; // RL17 RL19
            s_d.out_prev = outside;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign open_flag = s_q.open;
    assign alarm_flag = s_q.alarm;
endmodule // aufs_chan
`default_nettype wire

/* File: src/aufs_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module aufs_unit import aufs_pkg::*; #(
    parameter int INPUTS = AUFS_INPUTS
) (
    // Clock and reset (power-on)
    input wire logic pclk,
    input wire logic presetn,
    // Link
    aufs_link_if.unit link,
    // Unit setup
    input wire logic [AUFS_UNIT_W-1:0] unit_no,
    input wire logic unit_fail,
    // Per-input configuration and levels
    input wire logic [INPUTS-1:0] live_zero,
    input wire logic [INPUTS-1:0] below_thr,
    input wire logic [INPUTS-1:0] conv_inhibit,
    input wire logic [INPUTS-1:0][AUFS_DW-1:0] value,
    input wire logic [INPUTS-1:0][AUFS_DW-1:0] lim_lo,
    input wire logic [INPUTS-1:0][AUFS_DW-1:0] lim_hi,
    // Indicators and status
    output logic broken_wire_lamp,
    output logic run_lamp,
    output logic [AUFS_DW-1:0] input_fault_status
);
    typedef enum logic [0:0] {U_RUN, U_STOPPED} aufs_ust_e;
    typedef struct packed {
        aufs_ust_e st;
        logic restart_armed;
        logic reinit;
        logic ack;
        logic [AUFS_DW-1:0] data;
    } aufs_unit_s;

    aufs_unit_s s_q, s_d;
    logic [INPUTS-1:0] open_f, alarm_f;
    logic [AUFS_DW-1:0] status;

    // ----------------------------------------
    // Input channels
    // ----------------------------------------
    for (genvar i = 0; i < INPUTS; i++) begin : g_ch
        aufs_chan aufs_chan_inst (
            .pclk(pclk),
            .presetn(presetn),
            .sample(link.refresh_req && s_q.st == U_RUN),
            .reinit(s_q.reinit),
            .live_zero(live_zero[i]),
            .below_thr(below_thr[i]),
            .inhibit(conv_inhibit[i]),
            .value(value[i]),
            .lim_lo(lim_lo[i]),
            .lim_hi(lim_hi[i]),
            .open_flag(open_f[i]),
            .alarm_flag(alarm_f[i])
        );
    end

    always_comb begin
        status = '0;
        status[AUFS_OPEN_LSB +: INPUTS] = open_f; // RL2
        status[AUFS_ALARM_LSB +: INPUTS] = alarm_f; // RL5
    end

    // ----------------------------------------
    // Sequencing
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.reinit = 1'b0;
        // Off, on, off on the restart bit reinitialises the unit
        if (link.unit_restart_bit) begin
            s_d.restart_armed = 1'b1;
        end else if (s_q.restart_armed) begin
            s_d.restart_armed = 1'b0;
            s_d.reinit = 1'b1; // RL11
            s_d.st = U_RUN; // RL11
        end
        if (unit_fail) begin
            s_d.st = U_STOPPED; // RL9
        end
        // A stopped unit stays silent, so the host sees the failure
        if (link.refresh_req && s_q.st == U_RUN && !unit_fail) begin
            s_d.ack = 1'b1;
            s_d.data = (link.word_sel == AUFS_OFS_FAULT_STATUS) ? status : '0;
        end
    end

    // Power-on reset leaves the same state as a restart
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0; // RL14
        end else begin
            s_q <= s_d;
        end
    end

    assign link.unit_no = unit_no;
    assign link.refresh_ack = s_q.ack;
    assign link.refresh_words = s_q.data;
    assign broken_wire_lamp = |open_f; // RL3
    assign run_lamp = (s_q.st == U_RUN);
    assign input_fault_status = status;
endmodule // aufs_unit
`default_nettype wire

/* File: src/aufs_host.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// RL1 - Live-zero input below 1 V/4 mA: open flag
// RL2 - Open flags in bits 00-07, input order
// RL3 - Broken-wire lamp on if any open flag
// RL4 - Output value beyond limits sets range alarm
// RL5 - Range alarms in bits 08-15, input order
// RL6 - Duplicate unit number: summary bit, halt program
// RL7 - Duplicate flags name the duplicated unit number
// RL8 - Refresh failure: summary bit, keep running
// RL9 - Only the failing unit stops
// RL10 - Per-unit fault flag indexed by unit number
// RL11 - Restart bit off-on-off reinitialises the unit
// RL12 - Pulse restart after changing configuration
// RL13 - Pulse restart to resume after error (clears a refresh fault; a duplicate halt needs reset)
// RL14 - Power cycle acts like a restart pulse
// RL15 - Inhibit unused inputs to avoid open flags
// RL16 - Open detection only in live-zero range
// RL17 - Sub-scan out-of-limit excursions raise no alarm
// RL18 - Invalid or crossed limits disable range alarm
// RL19 - Flags re-evaluated each refresh, self-clearing
module aufs_host import aufs_pkg::*; #(
    parameter int SCAN_CYC = AUFS_SCAN_CYC,
    parameter int ACK_CYC = AUFS_ACK_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt
    output logic irq,
    // Link
    aufs_link_if.host_controller link
);
    typedef enum logic [1:0] {H_IDLE, H_WAIT, H_HALT} aufs_hst_e;
    typedef struct packed {
        aufs_hst_e st;
        logic [15:0] scan_cnt;
        logic [15:0] to_cnt;
        logic req;
        logic scan_en;
        logic [AUFS_UNITS-1:0] restart;
        logic [AUFS_UNITS-1:0] armed;
        logic [AUFS_UNITS-1:0] claim;
        logic [AUFS_UNITS-1:0] fault;
        logic [AUFS_UNITS-1:0] dup;
        logic summary;
        logic [AUFS_DW-1:0] word;
        logic [AUFS_IRQ_W-1:0] irq_stat;
        logic [AUFS_IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
    } aufs_host_s;

    aufs_host_s s_q, s_d;
    logic [AUFS_IRQ_W-1:0] ev;
    logic wr, rd_setup, mapped;
    logic [AUFS_UNIT_W-1:0] un;
    logic unit_ok;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    // No wait states: read data is captured in the setup cycle so it
    // leaves a flip-flop in the access cycle.
    always_comb begin
        wr = psel && penable && pwrite;
        rd_setup = psel && !penable && !pwrite;
        unique case (paddr)
            AUFS_A_CTRL, AUFS_A_CLAIM, AUFS_A_FAULT, AUFS_A_WORD, AUFS_A_IRQ_STAT, AUFS_A_IRQ_MASK: begin
                mapped = 1'b1;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
        un = link.unit_no;
        unit_ok = (32'(un) < AUFS_UNITS);
    end

    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;

    // ----------------------------------------
    // Scan, refresh and registers
    // ----------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.req = 1'b0;
        ev = '0;

        // Register writes
        if (wr) begin
            unique case (paddr)
                AUFS_A_CTRL: begin
                    s_d.scan_en = pwdata[AUFS_CTRL_SCAN_EN];
                    s_d.restart = pwdata[AUFS_CTRL_RESTART_LSB +: AUFS_UNITS];
                end
                AUFS_A_CLAIM: begin
                    s_d.claim = pwdata[AUFS_UNITS-1:0];
                end
                AUFS_A_IRQ_MASK: begin
                    s_d.irq_mask = pwdata[AUFS_IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Restart bit off-on-off clears that unit's fault
        for (int u = 0; u < AUFS_UNITS; u++) begin
            if (s_q.restart[u]) begin
                s_d.armed[u] = 1'b1;
            end else if (s_q.armed[u]) begin
                s_d.armed[u] = 1'b0;
                s_d.fault[u] = 1'b0; // RL11 RL13
            end
        end

        // Scan sequencer
        unique case (s_q.st)
            H_IDLE: begin
                if (!s_q.scan_en) begin
                    s_d.scan_cnt = '0;
                end else if (32'(s_q.scan_cnt) >= SCAN_CYC - 1) begin
                    s_d.scan_cnt = '0;
                    if (unit_ok && s_q.claim[un]) begin
                        // Number already taken: stop the whole program
                        s_d.dup[un] = 1'b1; // RL7
                        ev[AUFS_IRQ_DUP] = 1'b1;
                        s_d.st = H_HALT; // RL6
                    end else if (unit_ok && !s_q.fault[un]) begin
                        s_d.req = 1'b1;
                        s_d.to_cnt = '0;
                        s_d.st = H_WAIT;
                    end
                end else begin
                    s_d.scan_cnt = s_q.scan_cnt + 16'h0001;
                end
            end
            H_WAIT: begin
                s_d.scan_cnt = s_q.scan_cnt + 16'h0001;
                if (link.refresh_ack) begin
                    s_d.word = link.refresh_words;
                    ev[AUFS_IRQ_OPEN] = |link.refresh_words[AUFS_OPEN_LSB +: AUFS_INPUTS];
                    ev[AUFS_IRQ_ALARM] = |link.refresh_words[AUFS_ALARM_LSB +: AUFS_INPUTS];
                    s_d.st = H_IDLE;
                end else if (32'(s_q.to_cnt) >= ACK_CYC - 1) begin
                    // Only this unit is dropped; scanning goes on
                    s_d.fault[un] = 1'b1; // RL10 RL9
                    ev[AUFS_IRQ_FAULT] = 1'b1; // RL8
                    s_d.st = H_IDLE; // RL8
                end else begin
                    s_d.to_cnt = s_q.to_cnt + 16'h0001;
                end
            end
            H_HALT: begin
                s_d.scan_cnt = '0;
            end
            default: begin
                // Unused code: fall back to idle
                s_d.st = H_IDLE;
            end
        endcase

        s_d.summary = (|s_d.fault) || (|s_d.dup); // RL6 RL8

        // Set wins over a write-one clear in the same cycle
        if (wr && paddr == AUFS_A_IRQ_STAT) begin
            s_d.irq_stat = s_q.irq_stat & ~pwdata[AUFS_IRQ_W-1:0];
        end
        s_d.irq_stat = s_d.irq_stat | ev;

        // Read capture
        if (rd_setup) begin
            s_d.rdata = '0;
            unique case (paddr)
                AUFS_A_CTRL: begin
                    s_d.rdata[AUFS_CTRL_SCAN_EN] = s_q.scan_en;
                    s_d.rdata[AUFS_CTRL_RESTART_LSB +: AUFS_UNITS] = s_q.restart;
                end
                AUFS_A_CLAIM: begin
                    s_d.rdata[AUFS_UNITS-1:0] = s_q.claim;
                end
                AUFS_A_FAULT: begin
                    s_d.rdata[AUFS_UNITS-1:0] = s_q.fault;
                    s_d.rdata[AUFS_FAULT_DUP_LSB +: AUFS_UNITS] = s_q.dup;
                    s_d.rdata[AUFS_FAULT_HALT] = (s_q.st == H_HALT);
                    s_d.rdata[AUFS_FAULT_SUMMARY] = s_q.summary;
                end
                AUFS_A_WORD: begin
                    s_d.rdata[AUFS_DW-1:0] = s_q.word;
                end
                AUFS_A_IRQ_STAT: begin
                    s_d.rdata[AUFS_IRQ_W-1:0] = s_q.irq_stat;
                end
                AUFS_A_IRQ_MASK: begin
                    s_d.rdata[AUFS_IRQ_W-1:0] = s_q.irq_mask;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s_q.rdata;
    assign irq = |(s_q.irq_stat & s_q.irq_mask);
    assign link.refresh_req = s_q.req;
    assign link.word_sel = AUFS_OFS_FAULT_STATUS;
    // Software toggles this to apply new configuration
    assign link.unit_restart_bit = unit_ok ? s_q.restart[un] : 1'b0; // RL12 RL11
endmodule // aufs_host
`default_nettype wire

/* File: tb/aufs_link_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module aufs_link_asserts import aufs_pkg::*; #(
    parameter int ACK_CYC = AUFS_ACK_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Host to unit
    input wire logic refresh_req,
    input wire logic [3:0] word_sel,
    input wire logic unit_restart_bit,
    // Unit to host
    input wire logic [AUFS_UNIT_W-1:0] unit_no,
    input wire logic refresh_ack,
    input wire logic [AUFS_DW-1:0] refresh_words
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Helper state
    // ----------------------------------------
    logic [7:0] gap_q;
    logic pend_q;
    logic dead_q;
    logic rst_q;
    logic [1:0] acks_q;
    // History kept across restarts, so the alarm check can only be loose
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q <= 8'hff;
            pend_q <= 1'b0;
            dead_q <= 1'b0;
            rst_q <= 1'b0;
            acks_q <= 2'h0;
        end else begin
            gap_q <= refresh_req ? 8'h00 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h01);
            pend_q <= refresh_req;
            rst_q <= unit_restart_bit;
            if (rst_q && !unit_restart_bit) begin
                dead_q <= 1'b0;
            end else if (pend_q && !refresh_ack) begin
                dead_q <= 1'b1;
            end
            if (refresh_ack && acks_q != 2'h3) begin
                acks_q <= acks_q + 2'h1;
            end
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_req_pulse; refresh_req |=> !refresh_req; endproperty
    property p_ack_cause; refresh_ack |-> $past(refresh_req); endproperty
    property p_ack_pulse; refresh_ack |=> !refresh_ack; endproperty
    property p_word_sel; word_sel == AUFS_OFS_FAULT_STATUS; endproperty
    property p_words_hold; !refresh_ack |-> $stable(refresh_words); endproperty
    property p_alarm_two; refresh_ack && (|refresh_words[15:8]) |-> acks_q != 2'h0; endproperty
    property p_req_gap; refresh_req |-> gap_q >= ACK_CYC; endproperty
    property p_dead_quiet; refresh_req |-> !dead_q; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("refresh request longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_word_sel: assert property (p_word_sel) else $error("wrong status word selected");
    a_words_hold: assert property (p_words_hold) else $error("status word moved without ack");
    a_alarm_two: assert property (p_alarm_two) else $error("alarm on first sample");
    a_req_gap: assert property (p_req_gap) else $error("requests too close");
    a_dead_quiet: assert property (p_dead_quiet) else $error("request to stopped unit");
    c_open: cover property (refresh_ack && (|refresh_words[7:0]));
    c_alarm: cover property (refresh_ack && (|refresh_words[15:8]));
    c_restart: cover property (rst_q && !unit_restart_bit);
endmodule // aufs_link_asserts
`default_nettype wire

/* File: tb/aufs_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module aufs_tb_top import aufs_pkg::*;;
    localparam int SCAN_CYC = 20;
    localparam int ACK_CYC = 4;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, er, lamp, run;
    logic [3:0] unit_no = 4'h3;
    logic unit_fail = 1'b0;
    logic [7:0] live_zero = 8'h00, below_thr = 8'h00, inh = 8'h00;
    logic [7:0][15:0] value = {8{16'h2000}}, lim_lo = {8{16'h1000}}, lim_hi = {8{16'h3000}};
    logic [15:0] stat;
    int err_count = 0, checked = 0, cycles = 0;
    always #2.5 pclk = ~pclk;
    // ----------------------------------------
    // Design and checker
    // ----------------------------------------
    aufs_link_if link();
    aufs_host #(.SCAN_CYC(SCAN_CYC), .ACK_CYC(ACK_CYC)) aufs_host_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
    aufs_unit aufs_unit_inst (.pclk(pclk), .presetn(presetn), .link(link), .unit_no(unit_no),
        .unit_fail(unit_fail), .live_zero(live_zero), .below_thr(below_thr), .conv_inhibit(inh),
        .value(value), .lim_lo(lim_lo), .lim_hi(lim_hi), .broken_wire_lamp(lamp), .run_lamp(run),
        .input_fault_status(stat));
    aufs_link_asserts #(.ACK_CYC(ACK_CYC)) aufs_link_asserts_inst (.pclk(pclk), .presetn(presetn),
        .refresh_req(link.refresh_req), .word_sel(link.word_sel), .unit_restart_bit(link.unit_restart_bit),
        .unit_no(link.unit_no), .refresh_ack(link.refresh_ack), .refresh_words(link.refresh_words));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wait_ack();
        int i;
        for (i = 0; i < 4 * SCAN_CYC && link.refresh_ack !== 1'b1; i++) @(posedge pclk);
        `CHK("refresh ack", 1'b1, link.refresh_ack)
        repeat (2) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, AUFS_A_FAULT, 32'h0); `CHK("fault reset", 32'h0, rd)
        apb(1'b1, AUFS_A_FAULT, 32'hffffffff); apb(1'b0, AUFS_A_FAULT, 32'h0); `CHK("fault ro", 32'h0, rd)
        apb(1'b0, 8'h20, 32'h0); `CHK("unmapped err", 1'b1, er) `CHK("unmapped data", 32'h0, rd)
        apb(1'b1, AUFS_A_CTRL, 32'h1);
        // Open inputs: one inhibited, three not in live-zero range
        live_zero <= 8'h5b; below_thr <= 8'hff; inh <= 8'h08;
        wait_ack(); wait_ack();
        `CHK("open flags", 16'h0053, stat)
        `CHK("open lamp", 1'b1, lamp)
        apb(1'b0, AUFS_A_WORD, 32'h0); `CHK("status word", 32'h0053, rd)
        below_thr <= 8'h00;
        wait_ack();
        `CHK("open cleared", 16'h0000, stat)
        `CHK("lamp off", 1'b0, lamp)
        // Out of limits on inputs 1 and 8; bad limits on inputs 2 and 3
        value[0] <= 16'h3001; value[7] <= 16'h0fff; value[1] <= 16'h0500; value[2] <= 16'h0500;
        lim_hi[1] <= 16'h4001; lim_lo[2] <= 16'h3001;
        wait_ack();
        `CHK("alarm one scan", 16'h0000, stat)
        wait_ack();
        `CHK("alarm flags", 16'h8100, stat)
        value <= {8{16'h2000}};
        wait_ack(); wait_ack();
        `CHK("alarm cleared", 16'h0000, stat)
        // Interrupt status, mask and clear
        apb(1'b0, AUFS_A_IRQ_STAT, 32'h0); `CHK("irq stat", 32'h0000000c, rd)
        `CHK("irq masked", 1'b0, irq)
        apb(1'b1, AUFS_A_IRQ_MASK, 32'h9);
        `CHK("irq on", 1'b1, irq)
        apb(1'b1, AUFS_A_IRQ_STAT, 32'hc);
        `CHK("irq cleared", 1'b0, irq)
        // Broken unit stops, host carries on
        unit_fail <= 1'b1;
        repeat (3 * SCAN_CYC) @(posedge pclk);
        apb(1'b0, AUFS_A_FAULT, 32'h0); `CHK("unit fault", 32'h80000008, rd)
        `CHK("unit stopped", 1'b0, run)
        `CHK("irq fault", 1'b1, irq)
        unit_fail <= 1'b0;
        apb(1'b1, AUFS_A_CTRL, 32'h00080001);
        apb(1'b1, AUFS_A_CTRL, 32'h1);
        wait_ack();
        apb(1'b0, AUFS_A_FAULT, 32'h0); `CHK("fault cleared", 32'h0, rd)
        `CHK("unit running", 1'b1, run)
        // Flags left standing, so the power cycle has something to clear
        below_thr <= 8'h01;
        wait_ack();
        `CHK("open before reset", 16'h0001, stat)
        // Duplicate unit number halts the host
        apb(1'b1, AUFS_A_CLAIM, 32'h8);
        repeat (3 * SCAN_CYC) @(posedge pclk);
        apb(1'b0, AUFS_A_FAULT, 32'h0); `CHK("duplicate", 32'hc0080000, rd)
        apb(1'b0, AUFS_A_IRQ_STAT, 32'h0); `CHK("irq dup", 32'h00000003, rd)
        // Power cycle
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        `CHK("reset flags", 16'h0000, stat)
        `CHK("reset run", 1'b1, run)
        apb(1'b0, AUFS_A_FAULT, 32'h0); `CHK("reset fault", 32'h0, rd)
        end_sim();
    end
endmodule // aufs_tb_top
`default_nettype wire
